// ---- strap_wakeup_map.vh ----
// Register offsets, field positions, reset values and timing constants
// for the strap capture and standby wake-up block.
// Included by every design file of the block except the debouncer; definitions only.
`ifndef STRAP_WAKEUP_MAP_VH
`define STRAP_WAKEUP_MAP_VH

// Clock rate in kHz, so that cycles = milliseconds * rate.
`define CLK_KHZ 250000
`define DEBOUNCE_MS 16
`define RING_GAP_MS 200
`define LED_TICK_MS 125
`define DEBOUNCE_CYCLES (`DEBOUNCE_MS * `CLK_KHZ)
`define RING_GAP_CYCLES (`RING_GAP_MS * `CLK_KHZ)
`define LED_TICK_CYCLES (`LED_TICK_MS * `CLK_KHZ)

// Configuration index/data pair locations.
`define CFG_LOW_INDEX 16'h002e
`define CFG_HIGH_INDEX 16'h004e

// Register byte offsets.
`define REG_CTRL 8'h00
`define REG_LED 8'h04
`define REG_STANDBY 8'h08
`define REG_STRAPS 8'h0c
`define REG_STATE 8'h10
`define REG_INT_STATUS 8'h14
`define REG_INT_MASK 8'h18
`define REG_RING_CFG 8'h1c

// Control fields.
`define CTRL_SUPPLY_ON 0
`define CTRL_RING_WAKE_EN 1
`define CTRL_BTN_WAKE_EN 2
`define CTRL_WAKE_CLEAR 3
`define CTRL_RESET 8'h06

// Interrupt status fields.
`define INT_BUTTON 0
`define INT_RING 1
`define INT_SLEEP 2
`define INT_WIDTH 3

// Led rate codes.
`define LED_OFF 3'h0
`define LED_0HZ25 3'h1
`define LED_0HZ5 3'h2
`define LED_1HZ 3'h3
`define LED_4HZ 3'h4
`define LED_ON 3'h5
`define LED_RESET 8'h00

`define RING_CFG_RESET 4'h4

`endif

// ---- level_debounce.v ----
// Debounces one synchronised level.
// Assumes the input already passed a two-flop synchroniser.
`timescale 1ns/1ps
`default_nettype none
module level_debounce
#(
  parameter integer CYCLES = 4,
  parameter INIT = 1'b1
)
(
  input wire aclk,
  input wire aresetn,
  input wire din,
  output reg dout,
  output reg rise,
  output reg fall
);
  reg [31:0] cnt_reg;

  // A new level is accepted only after it held for CYCLES clocks. [RULE_18] [RULE_11]
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_reg <= 32'h0;
      dout <= INIT;
      rise <= 1'b0;
      fall <= 1'b0;
    end
    else
    begin
      rise <= 1'b0;
      fall <= 1'b0;
      if (din == dout)
        cnt_reg <= 32'h0;
      else if (cnt_reg == CYCLES - 1)
      begin
        cnt_reg <= 32'h0;
        dout <= din;
        rise <= din;
        fall <= ~din;
      end
      else
        cnt_reg <= cnt_reg + 32'h1;
    end
  end
endmodule
`default_nettype wire

// ---- led_blink.v ----
// Drives one standby LED at a selectable blink rate.
// Assumes the tick period is an eighth of a second.
`timescale 1ns/1ps
`default_nettype none
`include "strap_wakeup_map.vh"
module led_blink
#(
  parameter integer TICK_CYCLES = 31250000
)
(
  input wire aclk,
  input wire aresetn,
  input wire [2:0] rate,
  output reg led
);
  reg [31:0] pre_reg;
  reg [4:0] phase_reg;
  reg led_next;

  // Each phase bit toggles at a power-of-two fraction of the 8 Hz tick. [RULE_09]
  always @*
  begin
    case (rate)
      `LED_OFF: led_next = 1'b0;
      `LED_0HZ25: led_next = phase_reg[4];
      `LED_0HZ5: led_next = phase_reg[3];
      `LED_1HZ: led_next = phase_reg[2];
      `LED_4HZ: led_next = phase_reg[0];
      `LED_ON: led_next = 1'b1;
      default: led_next = 1'b0;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pre_reg <= 32'h0;
      phase_reg <= 5'h0;
      led <= 1'b0;
    end
    else
    begin
      led <= led_next;
      if (pre_reg == TICK_CYCLES - 1)
      begin
        pre_reg <= 32'h0;
        phase_reg <= phase_reg + 5'h1;
      end
      else
        pre_reg <= pre_reg + 32'h1;
    end
  end
endmodule
`default_nettype wire

// ---- strap_wakeup_ctrl.v ----
// Strap capture at the end of system reset and standby wake-up control,
// with an AXI4-Lite register slave.
// Assumes aresetn is the system reset; straps and pins are asynchronous,
// io_addr and uart1_term_ready_n come from logic on aclk.
//
// Behaviour
// [RULE_01] Capture base strap when reset ends.
// [RULE_02] Strap low: index/data at 2Eh-2Fh.
// [RULE_03] Strap high: index/data at 4Eh-4Fh.
// [RULE_04] Straps low: shared pins are power functions.
// [RULE_05] Straps high: shared pins become standby GPIO.
// [RULE_06] Polarity low: supply-on active low, open drain.
// [RULE_07] Polarity high: supply-on active high, push-pull.
// [RULE_08] Test strap high enters factory test mode.
// [RULE_09] LED rates: 0, 0.25, 0.5, 1, 4 Hz.
// [RULE_10] Supply-on active level switches supply on.
// [RULE_11] Button low is request, debounced 16 ms.
// [RULE_12] Button output driven low, open drain.
// [RULE_13] Wake event pulls power-up request low.
// [RULE_14] Ring pulse train is a wake event.
// [RULE_15] Controller drives the two sleep-state inputs.
// [RULE_16] Base strap pin returns to terminal-ready high.
// [RULE_17] Captured straps held until next reset.
// [RULE_18] Debounce counter needs stable level over interval.
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "strap_wakeup_map.vh"
module strap_wakeup_ctrl
#(
  parameter integer DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
  parameter integer RING_GAP_CYCLES = `RING_GAP_CYCLES,
  parameter integer LED_TICK_CYCLES = `LED_TICK_CYCLES
)
(
  input wire aclk,
  input wire aresetn,
  input wire [7:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  output wire arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  input wire cfg_base_strap,
  input wire psu_led_cfg_strap0,
  input wire psu_led_cfg_strap1,
  input wire supply_on_polarity_strap,
  input wire test_strap,
  input wire [15:0] io_addr,
  output wire cfg_index_hit,
  output wire cfg_data_hit,
  output reg test_mode,
  input wire uart1_term_ready_n,
  output reg uart1_term_ready_baud_out,
  output reg uart1_term_ready_baud_out_oe,
  output reg power_button_out,
  output reg power_button_out_oe,
  output reg supply_on_out,
  output reg supply_on_out_oe,
  input wire power_button_in,
  input wire sleep_state3_in,
  input wire sleep_state5_in,
  input wire ring_in_n,
  output reg power_up_request,
  output reg power_up_request_oe,
  output wire led1,
  output wire led2,
  output reg irq
);
  reg [8:0] sync1_reg;
  reg [8:0] sync2_reg;
  reg in_reset_reg;
  reg base_reg, psu0_reg, psu1_reg, pol_reg;
  reg [7:0] ctrl_reg, led_reg, mask_reg;
  reg [1:0] standby_reg;
  reg [3:0] ring_cfg_reg, ring_cnt_reg;
  reg [`INT_WIDTH-1:0] int_reg;
  reg [31:0] gap_reg;
  reg ring_prev_reg, sleep3_prev_reg, wake_reg;
  reg aw_have_reg, w_have_reg;
  reg [7:0] aw_addr_reg;
  reg [7:0] w_data_reg;
  reg w_lane_reg;
  reg [`INT_WIDTH-1:0] int_set;
  reg ring_event;
  wire gpio_mode;
  wire btn_level, btn_fall;
  wire do_write;
  wire [15:0] cfg_base;

  // Returns one when the byte address names a mapped register.
  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'b00) && (a <= `REG_RING_CFG);
    end
  endfunction

  // All pins and straps pass two flip-flops before any use.
  always @(posedge aclk)
  begin
    sync1_reg <= {ring_in_n, sleep_state5_in, sleep_state3_in, power_button_in,
      test_strap, supply_on_polarity_strap, psu_led_cfg_strap1,
      psu_led_cfg_strap0, cfg_base_strap};
    sync2_reg <= sync1_reg;
  end

  // Straps are sampled on the first clock after reset and then held. [RULE_01] [RULE_17]
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      in_reset_reg <= 1'b1;
      base_reg <= 1'b0;
      psu0_reg <= 1'b0;
      psu1_reg <= 1'b0;
      pol_reg <= 1'b0;
      test_mode <= 1'b0;
    end
    else if (in_reset_reg)
    begin
      in_reset_reg <= 1'b0;
      base_reg <= sync2_reg[0];
      psu0_reg <= sync2_reg[1];
      psu1_reg <= sync2_reg[2];
      pol_reg <= sync2_reg[3];
      test_mode <= sync2_reg[4]; // [RULE_08]
    end
  end

  // Either strap high selects the standby GPIO role of the shared pins. [RULE_04] [RULE_05]
  assign gpio_mode = psu0_reg | psu1_reg;
  assign cfg_base = base_reg ? `CFG_HIGH_INDEX : `CFG_LOW_INDEX; // [RULE_02] [RULE_03]
  assign cfg_index_hit = !in_reset_reg && (io_addr == cfg_base);
  assign cfg_data_hit = !in_reset_reg && (io_addr == cfg_base + 16'h0001);

  level_debounce #(.CYCLES(DEBOUNCE_CYCLES), .INIT(1'b1)) u_button
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(sync2_reg[5]),
    .dout(btn_level),
    .rise(),
    .fall(btn_fall)
  );

  led_blink #(.TICK_CYCLES(LED_TICK_CYCLES)) u_led1
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .rate(led_reg[2:0]),
    .led(led1)
  );

  led_blink #(.TICK_CYCLES(LED_TICK_CYCLES)) u_led2
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .rate(led_reg[6:4]),
    .led(led2)
  );

  // Falling ring edges close together form a train; a long gap restarts the count.
  always @*
  begin
    ring_event = ring_prev_reg && !sync2_reg[8] && (gap_reg < RING_GAP_CYCLES)
      && (ring_cnt_reg + 4'h1 >= ring_cfg_reg); // [RULE_14]
    int_set = {`INT_WIDTH{1'b0}};
    int_set[`INT_BUTTON] = btn_fall & !gpio_mode;
    int_set[`INT_RING] = ring_event;
    int_set[`INT_SLEEP] = sleep3_prev_reg ^ sync2_reg[6];
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ring_prev_reg <= 1'b1;
      sleep3_prev_reg <= 1'b1;
      ring_cnt_reg <= 4'h0;
      gap_reg <= 32'h0;
      wake_reg <= 1'b0;
    end
    else
    begin
      ring_prev_reg <= sync2_reg[8];
      sleep3_prev_reg <= sync2_reg[6];
      if (ring_prev_reg && !sync2_reg[8])
      begin
        gap_reg <= 32'h0;
        if (ring_event || gap_reg >= RING_GAP_CYCLES)
          ring_cnt_reg <= ring_event ? 4'h0 : 4'h1;
        else
          ring_cnt_reg <= ring_cnt_reg + 4'h1;
      end
      else if (gap_reg < RING_GAP_CYCLES)
        gap_reg <= gap_reg + 32'h1;
      // A new wake event wins over a clear in the same cycle. [RULE_13]
      if ((ring_event && ctrl_reg[`CTRL_RING_WAKE_EN])
        || (int_set[`INT_BUTTON] && ctrl_reg[`CTRL_BTN_WAKE_EN]))
        wake_reg <= 1'b1;
      else if (ctrl_reg[`CTRL_WAKE_CLEAR] || (!sleep3_prev_reg && sync2_reg[6]))
        wake_reg <= 1'b0;
    end
  end

  // Pin drivers; open-drain pins drive only low outside standby GPIO mode.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      power_button_out <= 1'b0;
      power_button_out_oe <= 1'b0;
      supply_on_out <= 1'b0;
      supply_on_out_oe <= 1'b0;
      power_up_request <= 1'b0;
      power_up_request_oe <= 1'b0;
      uart1_term_ready_baud_out <= 1'b1;
      uart1_term_ready_baud_out_oe <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      // The strap pin is released back to the serial port once sampled. [RULE_16]
      uart1_term_ready_baud_out <= in_reset_reg ? 1'b1 : uart1_term_ready_n;
      uart1_term_ready_baud_out_oe <= !in_reset_reg;
      power_up_request <= 1'b0;
      power_up_request_oe <= wake_reg; // [RULE_13]
      irq <= |(int_reg & mask_reg[`INT_WIDTH-1:0]);
      if (gpio_mode || in_reset_reg)
      begin
        power_button_out <= standby_reg[0]; // [RULE_05]
        power_button_out_oe <= !in_reset_reg;
        supply_on_out <= standby_reg[1];
        supply_on_out_oe <= !in_reset_reg;
      end
      else
      begin
        power_button_out <= 1'b0;
        power_button_out_oe <= !btn_level; // [RULE_12]
        if (pol_reg)
        begin
          supply_on_out <= ctrl_reg[`CTRL_SUPPLY_ON]; // [RULE_07] [RULE_10]
          supply_on_out_oe <= 1'b1;
        end
        else
        begin
          supply_on_out <= 1'b0;
          supply_on_out_oe <= ctrl_reg[`CTRL_SUPPLY_ON]; // [RULE_06] [RULE_10]
        end
      end
    end
  end

  // AXI4-Lite write path: address and data are taken in either order.
  assign awready = !aw_have_reg && !bvalid;
  assign wready = !w_have_reg && !bvalid;
  assign do_write = aw_have_reg && w_have_reg && !bvalid;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      ctrl_reg <= `CTRL_RESET;
      led_reg <= `LED_RESET;
      mask_reg <= 8'h00;
      standby_reg <= 2'b00;
      ring_cfg_reg <= `RING_CFG_RESET;
      int_reg <= {`INT_WIDTH{1'b0}};
    end
    else
    begin
      ctrl_reg[`CTRL_WAKE_CLEAR] <= 1'b0;
      if (awvalid && awready)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_have_reg <= 1'b1;
        w_data_reg <= wdata[7:0];
        w_lane_reg <= wstrb[0];
      end
      if (bvalid && bready)
        bvalid <= 1'b0;
      int_reg <= int_reg | int_set;
      if (do_write)
      begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        bvalid <= 1'b1;
        bresp <= mapped(aw_addr_reg) ? 2'b00 : 2'b10;
        if (w_lane_reg)
        begin
          case (aw_addr_reg)
            `REG_CTRL: ctrl_reg <= {4'h0, w_data_reg[3:0]};
            `REG_LED: led_reg <= {1'b0, w_data_reg[6:4], 1'b0, w_data_reg[2:0]};
            `REG_STANDBY: standby_reg <= w_data_reg[1:0];
            `REG_INT_STATUS: int_reg <= (int_reg & ~w_data_reg[`INT_WIDTH-1:0]) | int_set;
            `REG_INT_MASK: mask_reg <= {5'h00, w_data_reg[`INT_WIDTH-1:0]};
            `REG_RING_CFG: ring_cfg_reg <= w_data_reg[3:0];
            default: ctrl_reg[`CTRL_WAKE_CLEAR] <= 1'b0;
          endcase
        end
      end
    end
  end

  // AXI4-Lite read path: one read at a time, answer one cycle after address.
  assign arready = !rvalid;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'b00;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rresp <= mapped(araddr) ? 2'b00 : 2'b10;
      case (araddr)
        `REG_CTRL: rdata <= {24'h0, ctrl_reg};
        `REG_LED: rdata <= {24'h0, led_reg};
        `REG_STANDBY: rdata <= {29'h0, ~sync2_reg[5] ^ 1'b1, standby_reg};
        `REG_STRAPS: rdata <= {26'h0, gpio_mode, test_mode, pol_reg, psu1_reg,
          psu0_reg, base_reg};
        `REG_STATE: rdata <= {27'h0, ctrl_reg[`CTRL_SUPPLY_ON], wake_reg,
          !sync2_reg[7], !sync2_reg[6], !btn_level};
        `REG_INT_STATUS: rdata <= {29'h0, int_reg};
        `REG_INT_MASK: rdata <= {24'h0, mask_reg};
        `REG_RING_CFG: rdata <= {28'h0, ring_cfg_reg};
        default: rdata <= 32'h0;
      endcase
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end
endmodule
`default_nettype wire

// ---- strap_wakeup_monitor.sv ----
// Checker for strap capture, pin modes and button debounce.
// Assumes straps stay steady over the last cycles of every reset.
`timescale 1ns/1ps
`default_nettype none
`include "strap_wakeup_map.vh"
module strap_wakeup_monitor
#(
  parameter integer DEBOUNCE_CYCLES = 8
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cfg_base_strap,
  input wire logic psu_led_cfg_strap0,
  input wire logic psu_led_cfg_strap1,
  input wire logic supply_on_polarity_strap,
  input wire logic test_strap,
  input wire logic [15:0] io_addr,
  input wire logic cfg_index_hit,
  input wire logic cfg_data_hit,
  input wire logic test_mode,
  input wire logic uart1_term_ready_n,
  input wire logic uart1_term_ready_baud_out,
  input wire logic uart1_term_ready_baud_out_oe,
  input wire logic power_button_out,
  input wire logic power_button_out_oe,
  input wire logic supply_on_out,
  input wire logic supply_on_out_oe,
  input wire logic power_button_in,
  input wire logic power_up_request
);
  logic cap_base, cap_psu0, cap_psu1, cap_pol, cap_test;
  logic [2:0] up;
  int low_cnt, last_run;
  wire gp = cap_psu0 | cap_psu1;
  wire settled = up == 3'h4;
  wire [15:0] base = cap_base ? `CFG_HIGH_INDEX : `CFG_LOW_INDEX;
  // The straps seen at the end of reset are what the block must keep afterwards.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cap_base <= cfg_base_strap;
      cap_psu0 <= psu_led_cfg_strap0;
      cap_psu1 <= psu_led_cfg_strap1;
      cap_pol <= supply_on_polarity_strap;
      cap_test <= test_strap;
      up <= 3'h0;
    end
    else if (!settled)
      up <= up + 3'h1;
  end
  // Length of the current low run of the button and of the one before it.
  always @(posedge aclk)
  begin
    if (!aresetn || power_button_in)
      low_cnt <= 0;
    else
      low_cnt <= low_cnt + 1;
    if (!aresetn)
      last_run <= 0;
    else if (power_button_in && low_cnt != 0)
      last_run <= low_cnt;
  end
  default clocking mon_clk @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_decode;
    settled |-> cfg_index_hit == (io_addr == base) && cfg_data_hit == (io_addr == base + 16'h1);
  endproperty
  a_decode: assert property (p_decode)
    else $error("index or data decode wrong");
  property p_test;
    settled |-> test_mode == cap_test;
  endproperty
  a_test: assert property (p_test)
    else $error("test mode differs from strap");
  property p_uart;
    settled |=> uart1_term_ready_baud_out_oe && uart1_term_ready_baud_out == $past(uart1_term_ready_n);
  endproperty
  a_uart: assert property (p_uart)
    else $error("shared strap pin not back to terminal ready");
  property p_pol;
    settled && !gp |-> (cap_pol ? supply_on_out_oe : !supply_on_out);
  endproperty
  a_pol: assert property (p_pol)
    else $error("supply on driver type wrong");
  property p_gpio;
    settled && gp |-> power_button_out_oe && supply_on_out_oe;
  endproperty
  a_gpio: assert property (p_gpio)
    else $error("standby outputs not driven");
  property p_btn;
    settled && !gp && power_button_out_oe |-> !power_button_out;
  endproperty
  a_btn: assert property (p_btn)
    else $error("button output not open drain low");
  property p_pwu;
    settled |-> !power_up_request;
  endproperty
  a_pwu: assert property (p_pwu)
    else $error("power-up request driven high");
  property p_deb_early;
    settled && !gp && $rose(power_button_out_oe)
      |-> low_cnt >= DEBOUNCE_CYCLES || last_run >= DEBOUNCE_CYCLES;
  endproperty
  a_deb_early: assert property (p_deb_early)
    else $error("button passed before debounce");
  property p_deb_late;
    settled && !gp && low_cnt == DEBOUNCE_CYCLES + 8 |-> power_button_out_oe;
  endproperty
  a_deb_late: assert property (p_deb_late)
    else $error("steady press not passed on");
endmodule
`default_nettype wire

// ---- platform_model.sv ----
// Platform model: power button, ring line and sleep-state lines.
// Assumes the bench calls its tasks; idle lines rest at their pull-ups.
`timescale 1ns/1ps
`default_nettype none
module platform_model
(
  input wire logic aclk,
  output var logic power_button_in,
  output var logic ring_in_n,
  output var logic sleep_state3_in,
  output var logic sleep_state5_in
);
  // The system starts awake, so both sleep lines read inactive.
  initial
  begin
    power_button_in = 1'b1;
    ring_in_n = 1'b1;
    sleep_state3_in = 1'b1;
    sleep_state5_in = 1'b1;
  end
  task automatic set_sleep(input bit s3, input bit s5);
    @(posedge aclk);
    sleep_state3_in <= s3;
    sleep_state5_in <= s5;
  endtask
  task automatic press(input int cycles);
    @(posedge aclk);
    power_button_in <= 1'b0;
    repeat (cycles) @(posedge aclk);
    power_button_in <= 1'b1;
  endtask
  // Pulses sit well inside the ring gap so that they form one train.
  task automatic ring(input int pulses);
    repeat (pulses)
    begin
      @(posedge aclk);
      ring_in_n <= 1'b0;
      repeat (3) @(posedge aclk);
      ring_in_n <= 1'b1;
      repeat (6) @(posedge aclk);
    end
  endtask
endmodule
`default_nettype wire

// ---- strap_and_wakeup_control_tb_top.sv ----
// Bench for strap capture, standby pins, leds and wake-up events.
// Assumes the platform model drives the button, ring and sleep lines.
`timescale 1ns/1ps
`default_nettype none
`include "strap_wakeup_map.vh"
module strap_and_wakeup_control_tb_top;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, uart1_term_ready_n = 1'b1;
  logic cfg_base_strap, psu_led_cfg_strap0 = 1'b0, psu_led_cfg_strap1 = 1'b0;
  logic supply_on_polarity_strap, test_strap;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic [15:0] io_addr = 16'h0;
  wire awready, wready, bvalid, arready, rvalid, cfg_index_hit, cfg_data_hit, test_mode;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire uart1_term_ready_baud_out, uart1_term_ready_baud_out_oe, power_button_out;
  wire power_button_out_oe, supply_on_out, supply_on_out_oe, power_up_request;
  wire power_up_request_oe, led1, led2, irq;
  wire power_button_in, sleep_state3_in, sleep_state5_in, ring_in_n;
  // Both pins have pull-ups, so a released pin reads high.
  wire button_pin = power_button_out_oe ? power_button_out : 1'b1;
  wire supply_pin = supply_on_out_oe ? supply_on_out : 1'b1;
  logic [33:0] q[$];
  int num_errors = 0, tests_run = 0, cyc = 0, n, i;
  integer seed = 32'h13d0;
  int per[4] = '{128, 64, 32, 8};
  always #2 aclk = ~aclk;
  strap_wakeup_ctrl #(.DEBOUNCE_CYCLES(8), .RING_GAP_CYCLES(200), .LED_TICK_CYCLES(4))
  strap_wakeup_ctrl_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .cfg_base_strap, .psu_led_cfg_strap0, .psu_led_cfg_strap1,
    .supply_on_polarity_strap, .test_strap, .io_addr, .cfg_index_hit, .cfg_data_hit,
    .test_mode, .uart1_term_ready_n, .uart1_term_ready_baud_out, .uart1_term_ready_baud_out_oe,
    .power_button_out, .power_button_out_oe, .supply_on_out, .supply_on_out_oe,
    .power_button_in, .sleep_state3_in, .sleep_state5_in, .ring_in_n, .power_up_request,
    .power_up_request_oe, .led1, .led2, .irq);
  platform_model platform_model_inst (.aclk, .power_button_in, .ring_in_n,
    .sleep_state3_in, .sleep_state5_in);
  task automatic err(input string m);
    $display("Error at %0t: %s", $time, m);
    num_errors++;
  endtask
  task automatic chk(input logic got, input logic exp, input string m);
    tests_run++;
    if (got !== exp)
      err(m);
  endtask
  task automatic close_out();
    $display("Mismatches %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One bus transfer; handshakes are judged on values that stand until the next edge.
  task automatic xfer(input bit rd, input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r);
    bit h1, h2, h3, h4;
    @(posedge aclk);
    q.push_back({r, d});
    if (rd)
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    else
    begin
      awaddr <= a;
      wdata <= d;
      wstrb <= {3'($random(seed)), 1'b1};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end
    do
    begin
      @(negedge aclk);
      h1 = awvalid && awready;
      h2 = wvalid && wready;
      h3 = arvalid && arready;
      h4 = (bvalid && bready) || (rvalid && rready);
      @(posedge aclk);
      if (h1)
        awvalid <= 1'b0;
      if (h2)
        wvalid <= 1'b0;
      if (h3)
        arvalid <= 1'b0;
    end
    while (!h4);
    bready <= 1'b0;
    rready <= 1'b0;
  endtask
  task automatic led_period(output int p);
    while (led1 !== 1'b0) @(negedge aclk);
    while (led1 !== 1'b1) @(negedge aclk);
    for (p = 0; led1 !== 1'b0; p++) @(negedge aclk);
    for (; led1 !== 1'b1; p++) @(negedge aclk);
  endtask
  always @(negedge aclk)
  begin
    if ((bvalid && bready) || (rvalid && rready))
    begin
      tests_run++;
      if (q.size() == 0)
        err("answer without request");
      else if (bvalid ? (bresp !== q[0][33:32]) : ({rresp, rdata} !== q[0]))
        err("bus answer mismatch");
      if (q.size() != 0)
        q.delete(0);
    end
  end
  always @(posedge aclk)
  begin
    uart1_term_ready_n <= $random(seed) % 2 != 0;
    cyc++;
    if (cyc == 20000)
    begin
      err("timeout");
      close_out();
    end
  end
  initial
  begin
    {cfg_base_strap, supply_on_polarity_strap, test_strap} = 3'($random(seed));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    for (i = 0; i < 4; i++)
    begin
      io_addr <= 16'h002e + 16'(32 * (i / 2) + i % 2);
      @(negedge aclk);
      chk(cfg_index_hit, io_addr == (cfg_base_strap ? 16'h004e : 16'h002e), "index");
      chk(cfg_data_hit, io_addr == (cfg_base_strap ? 16'h004f : 16'h002f), "data");
      @(posedge aclk);
    end
    chk(test_mode, test_strap, "test mode");
    xfer(1, `REG_STRAPS, {27'h0, test_strap, supply_on_polarity_strap, 2'b00, cfg_base_strap}, 2'b00);
    xfer(1, `REG_CTRL, 32'h6, 2'b00);
    xfer(1, `REG_RING_CFG, 32'h4, 2'b00);
    xfer(0, 8'h20, 32'h0, 2'b10);
    xfer(0, `REG_CTRL, 32'h7, 2'b00);
    repeat (3) @(negedge aclk);
    chk(supply_pin, supply_on_polarity_strap, "supply on");
    xfer(0, `REG_CTRL, 32'h6, 2'b00);
    repeat (3) @(negedge aclk);
    chk(supply_pin, !supply_on_polarity_strap, "supply off");
    xfer(0, `REG_INT_MASK, 32'h3, 2'b00);
    platform_model_inst.press(4);
    repeat (20) @(negedge aclk);
    chk(button_pin, 1'b1, "glitch passed");
    fork
      platform_model_inst.press(30);
    join_none
    repeat (20) @(negedge aclk);
    chk(button_pin, 1'b0, "press lost");
    chk(irq, 1'b1, "no interrupt");
    xfer(1, `REG_INT_STATUS, 32'h1, 2'b00);
    xfer(0, `REG_INT_STATUS, 32'h1, 2'b00);
    @(negedge aclk);
    chk(irq, 1'b0, "interrupt stuck");
    chk(power_up_request_oe, 1'b1, "no wake");
    xfer(0, `REG_CTRL, 32'he, 2'b00);
    repeat (3) @(negedge aclk);
    chk(power_up_request_oe, 1'b0, "wake not cleared");
    platform_model_inst.ring(3);
    repeat (250) @(negedge aclk);
    xfer(1, `REG_INT_STATUS, 32'h0, 2'b00);
    platform_model_inst.ring(4);
    repeat (6) @(negedge aclk);
    chk(power_up_request_oe, 1'b1, "ring wake");
    xfer(1, `REG_INT_STATUS, 32'h2, 2'b00);
    platform_model_inst.set_sleep(1'b0, 1'b0);
    repeat (6) @(negedge aclk);
    xfer(1, `REG_STATE, 32'he, 2'b00);
    platform_model_inst.set_sleep(1'b1, 1'b1);
    repeat (6) @(negedge aclk);
    chk(power_up_request_oe, 1'b0, "wake kept after resume");
    xfer(1, `REG_INT_STATUS, 32'h6, 2'b00);
    for (i = 1; i < 5; i++)
    begin
      xfer(0, `REG_LED, 32'(i), 2'b00);
      led_period(n);
      led_period(n);
      chk(n == per[i - 1], 1'b1, "led period");
    end
    xfer(0, `REG_LED, 32'h50, 2'b00);
    repeat (8) @(negedge aclk);
    chk(led2, 1'b1, "led2 on");
    chk(led1, 1'b0, "led1 off");
    @(posedge aclk);
    aresetn <= 1'b0;
    psu_led_cfg_strap0 <= $random(seed) % 2 != 0;
    psu_led_cfg_strap1 <= 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    n = cfg_base_strap;
    cfg_base_strap <= !cfg_base_strap;
    xfer(1, `REG_STRAPS, {26'h0, 1'b1, test_strap, supply_on_polarity_strap, 1'b1,
      psu_led_cfg_strap0, n[0]}, 2'b00);
    xfer(0, `REG_STANDBY, 32'h1, 2'b00);
    repeat (3) @(negedge aclk);
    chk(button_pin, 1'b1, "standby out0");
    chk(supply_pin, 1'b0, "standby out1");
    xfer(1, `REG_STANDBY, 32'h5, 2'b00);
    close_out();
  end
endmodule
bind strap_wakeup_ctrl strap_wakeup_monitor #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES))
strap_wakeup_monitor_inst (.aclk, .aresetn, .cfg_base_strap, .psu_led_cfg_strap0,
  .psu_led_cfg_strap1, .supply_on_polarity_strap, .test_strap, .io_addr, .cfg_index_hit,
  .cfg_data_hit, .test_mode, .uart1_term_ready_n, .uart1_term_ready_baud_out,
  .uart1_term_ready_baud_out_oe, .power_button_out, .power_button_out_oe, .supply_on_out,
  .supply_on_out_oe, .power_button_in, .power_up_request);
`default_nettype wire
